/* tpm_channel_pkg.sv */
package timer_channel_pkg;

   localparam int VAL_W = 16;
   localparam int INT_W = 2;

   localparam logic [7:0] OFS_CTL       = 8'h00;
   localparam logic [7:0] OFS_VAL_HI    = 8'h04;
   localparam logic [7:0] OFS_VAL_LO    = 8'h08;
   localparam logic [7:0] OFS_INT_STAT  = 8'h0c;
   localparam logic [7:0] OFS_INT_MASK  = 8'h10;
   localparam logic [7:0] OFS_PIN_STATE = 8'h14;

   localparam int CTL_CPWM_BIT = 0;
   localparam int CTL_ELSA_BIT = 2;
   localparam int CTL_ELSB_BIT = 3;
   localparam int CTL_MSA_BIT  = 4;
   localparam int CTL_MSB_BIT  = 5;

   localparam int INT_CAPTURE_BIT = 0;
   localparam int INT_MATCH_BIT   = 1;

   localparam logic [7:0]       CTL_RESET  = 8'h00;
   localparam logic [VAL_W-1:0] VAL_RESET  = 16'h0000;
   localparam logic [INT_W-1:0] MASK_RESET = 2'h0;
   localparam logic [INT_W-1:0] STAT_RESET = 2'h0;

   typedef enum logic [2:0] {
      MODE_OFF,
      MODE_CAPTURE,
      MODE_COMPARE,
      MODE_EPWM,
      MODE_CPWM
   } chan_mode_e;

   function automatic chan_mode_e mode_decode(input logic [7:0] ctl);
      chan_mode_e m;
      if (ctl[CTL_ELSB_BIT:CTL_ELSA_BIT] == 2'h0) begin
         m = MODE_OFF;
      end else if (ctl[CTL_CPWM_BIT]) begin
         m = MODE_CPWM;
      end else if (ctl[CTL_MSB_BIT]) begin
         m = MODE_EPWM;
      end else if (ctl[CTL_MSA_BIT]) begin
         m = MODE_COMPARE;
      end else begin
         m = MODE_CAPTURE;
      end
      return m;
   endfunction

endpackage

/* pin_edge_sync.sv */
`timescale 1ns/1ps
module pin_edge_sync (
   input  wire logic clk_i,   // Bus clock
   input  wire logic srst_i,  // Synchronous reset, active high
   input  wire logic pin_i,   // Asynchronous pin level
   output logic      level_o, // Synchronised level
   output logic      rise_o,  // One-cycle rising edge
   output logic      fall_o   // One-cycle falling edge
);
   logic meta_reg;
   logic sync_reg;
   logic prev_reg;

   // Meta stage is read only by the second stage
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         meta_reg <= pin_i;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign level_o = sync_reg;
   assign rise_o  = sync_reg & ~prev_reg;
   assign fall_o  = ~sync_reg & prev_reg;
endmodule // pin_edge_sync

/* tpm_channel.sv */
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module timer_channel
   import timer_channel_pkg::*;
(
   input  wire logic             CLK_SYS_I,    // Bus clock, 40 MHz
   input  wire logic             SRST_I,       // Synchronous reset, active high
   input  wire logic             PSEL_I,       // APB select
   input  wire logic             PENABLE_I,    // APB enable
   input  wire logic             PWRITE_I,     // APB direction
   input  wire logic [7:0]       PADDR_I,      // APB byte address
   input  wire logic [31:0]      PWDATA_I,     // APB write data
   output logic      [31:0]      PRDATA_O,     // APB read data
   output logic                  PREADY_O,     // APB ready
   output logic                  PSLVERR_O,    // APB error, unmapped address
   input  wire logic [VAL_W-1:0] COUNT_I,      // Shared timer counter
   input  wire logic             COUNT_DOWN_I, // Counter counting down
   input  wire logic             OVF_I,        // Counter wrap pulse
   input  wire logic             PIN_I,        // Channel pin level
   output logic                  PIN_O,        // Channel pin drive level
   output logic                  PIN_OE_O,     // Channel owns the pin
   output logic                  IRQ_O         // Level interrupt
);

   logic [7:0]       ctl_reg;
   logic [VAL_W-1:0] value_reg;
   logic [INT_W-1:0] stat_reg;
   logic [INT_W-1:0] stat_next;
   logic [INT_W-1:0] mask_reg;
   logic [31:0]      rdata_reg;
   logic             ready_reg;
   logic             err_reg;
   logic             pin_reg;
   logic             pin_next;
   logic             oe_reg;
   logic             irq_reg;

   logic             pin_lvl;
   logic             pin_rise;
   logic             pin_fall;
   chan_mode_e       mode;
   logic [1:0]       els;
   logic             capture_evt;
   logic             match_evt;
   logic             xfer_done;
   logic             wr_en;
   logic             rd_en;
   logic             addr_ok;
   logic [31:0]      rdata_next;

   pin_edge_sync u_sync (
      .clk_i   (CLK_SYS_I),
      .srst_i  (SRST_I),
      .pin_i   (PIN_I),
      .level_o (pin_lvl),
      .rise_o  (pin_rise),
      .fall_o  (pin_fall)
   );

   // ---------------- APB slave ----------------
   // One wait state: ready rises in the second access cycle
   assign xfer_done = PSEL_I & PENABLE_I & ready_reg;
   assign wr_en     = xfer_done & PWRITE_I;
   assign rd_en     = xfer_done & ~PWRITE_I;
   assign addr_ok   = (PADDR_I == OFS_CTL) || (PADDR_I == OFS_VAL_HI) ||
                      (PADDR_I == OFS_VAL_LO) || (PADDR_I == OFS_INT_STAT) ||
                      (PADDR_I == OFS_INT_MASK) || (PADDR_I == OFS_PIN_STATE);

   always_comb begin
      rdata_next = 32'h0000_0000;
      case (PADDR_I)
         OFS_CTL:       rdata_next[7:0] = ctl_reg;
         OFS_VAL_HI:    rdata_next[7:0] = value_reg[15:8];
         OFS_VAL_LO:    rdata_next[7:0] = value_reg[7:0];
         OFS_INT_STAT:  rdata_next[INT_W-1:0] = stat_reg;
         OFS_INT_MASK:  rdata_next[INT_W-1:0] = mask_reg;
         OFS_PIN_STATE: rdata_next[2:0] = {pin_lvl, pin_reg, oe_reg};
         default:       rdata_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         ready_reg <= 1'b0;
         err_reg   <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end else begin
         ready_reg <= PSEL_I & PENABLE_I & ~ready_reg;
         err_reg   <= PSEL_I & PENABLE_I & ~ready_reg & ~addr_ok;
         if (PSEL_I & PENABLE_I & ~ready_reg) begin
            rdata_reg <= rdata_next;
         end
      end
   end

   // ---------------- Control and mask ----------------
   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         ctl_reg  <= CTL_RESET;
         mask_reg <= MASK_RESET;
      end else if (wr_en) begin
         if (PADDR_I == OFS_CTL) begin
            ctl_reg <= PWDATA_I[7:0];
         end
         if (PADDR_I == OFS_INT_MASK) begin
            mask_reg <= PWDATA_I[INT_W-1:0];
         end
      end
   end

   assign mode = mode_decode(ctl_reg);
   assign els  = ctl_reg[CTL_ELSB_BIT:CTL_ELSA_BIT];

   // ---------------- Capture and compare ----------------
   // Early edges right after entering capture mode are trusted as real
   always_comb begin
      capture_evt = 1'b0;
      if (mode == MODE_CAPTURE) begin
         case (els)
            2'h1:    capture_evt = pin_rise;
            2'h2:    capture_evt = pin_fall;
            2'h3:    capture_evt = pin_rise | pin_fall;
            default: capture_evt = 1'b0;
         endcase
      end
   end

   assign match_evt = (mode == MODE_COMPARE || mode == MODE_EPWM || mode == MODE_CPWM) &&
                      (COUNT_I == value_reg);

   // A capture in the same cycle as a software write wins: the edge is not lost
   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         value_reg <= VAL_RESET;
      end else if (capture_evt) begin
         value_reg <= COUNT_I;
      end else if (wr_en && PADDR_I == OFS_VAL_HI) begin
         value_reg[15:8] <= PWDATA_I[7:0];
      end else if (wr_en && PADDR_I == OFS_VAL_LO) begin
         value_reg[7:0] <= PWDATA_I[7:0];
      end
   end

   // ---------------- Pin drive ----------------
   always_comb begin
      pin_next = pin_reg;
      case (mode)
         MODE_COMPARE: begin
            if (match_evt) begin
               case (els)
                  2'h1:    pin_next = ~pin_reg;
                  2'h2:    pin_next = 1'b0;
                  default: pin_next = 1'b1;
               endcase
            end
         end
         MODE_EPWM: begin
            // Match beats wrap so a zero value gives 0 % duty
            if (match_evt) begin
               pin_next = els[0];
            end else if (OVF_I) begin
               pin_next = ~els[0];
            end
         end
         MODE_CPWM: begin
            if (match_evt) begin
               pin_next = COUNT_DOWN_I ? ~els[0] : els[0];
            end
         end
         default: pin_next = pin_reg;
      endcase
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         pin_reg <= 1'b0;
         oe_reg  <= 1'b0;
      end else begin
         pin_reg <= pin_next;
         oe_reg  <= (mode != MODE_OFF) && (mode != MODE_CAPTURE);
      end
   end

   // ---------------- Interrupts ----------------
   // Set beats the read-clear so an event in the clearing cycle survives.
   // Only the bits that the read returned are cleared: the read data is a
   // snapshot taken one cycle before completion, and an event landing in
   // that gap must not be wiped unseen.
   always_comb begin
      stat_next = stat_reg;
      if (rd_en && PADDR_I == OFS_INT_STAT) begin
         stat_next = stat_reg & ~rdata_reg[INT_W-1:0];
      end
      stat_next[INT_CAPTURE_BIT] = stat_next[INT_CAPTURE_BIT] | capture_evt;
      stat_next[INT_MATCH_BIT]   = stat_next[INT_MATCH_BIT] | match_evt;
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         stat_reg <= STAT_RESET;
         irq_reg  <= 1'b0;
      end else begin
         stat_reg <= stat_next;
         irq_reg  <= |(stat_reg & mask_reg);
      end
   end

   assign PRDATA_O  = rdata_reg;
   assign PREADY_O  = ready_reg;
   assign PSLVERR_O = err_reg;
   assign PIN_O     = pin_reg;
   assign PIN_OE_O  = oe_reg;
   assign IRQ_O     = irq_reg;

   // ---------------- Assertions ----------------
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (SRST_I);

   a_detach_pin: assert property (
      (els == 2'h0) |=> !PIN_OE_O)
      else $error("pin driven while edge/level select is 00");

   a_capture_input: assert property (
      (!ctl_reg[CTL_CPWM_BIT] && !ctl_reg[CTL_MSB_BIT] && !ctl_reg[CTL_MSA_BIT] && els != 2'h0)
      |=> !PIN_OE_O)
      else $error("pin driven in input capture mode");

   a_compare_drive: assert property (
      (!ctl_reg[CTL_CPWM_BIT] && !ctl_reg[CTL_MSB_BIT] && ctl_reg[CTL_MSA_BIT] && els != 2'h0)
      |=> PIN_OE_O)
      else $error("pin not driven in output compare mode");

   a_capture_rise: assert property (
      (mode == MODE_CAPTURE && els == 2'h1 && $rose(pin_lvl))
      |=> value_reg == $past(COUNT_I))
      else $error("rising edge did not capture counter");

   a_capture_ignore: assert property (
      (mode == MODE_CAPTURE && els == 2'h1 && $fell(pin_lvl) && !wr_en)
      |=> $stable(value_reg))
      else $error("falling edge captured in rising-only mode");

   a_capture_value: assert property (
      (mode == MODE_CAPTURE && els == 2'h3 && (pin_rise || pin_fall))
      |=> value_reg == $past(COUNT_I) && stat_reg[INT_CAPTURE_BIT])
      else $error("either-edge capture lost value or flag");

   a_compare_toggle: assert property (
      (mode == MODE_COMPARE && els == 2'h1 && COUNT_I == value_reg)
      |=> PIN_O != $past(PIN_O))
      else $error("compare match did not toggle pin");

   a_compare_level: assert property (
      (mode == MODE_COMPARE && els[1] && COUNT_I == value_reg)
      |=> PIN_O == $past(els[0]))
      else $error("compare match drove wrong level");

   a_edge_pwm: assert property (
      (mode == MODE_EPWM && COUNT_I != value_reg && OVF_I)
      |=> PIN_O == !$past(els[0]) ##0 PIN_OE_O)
      else $error("edge PWM wrong level at wrap");

   a_center_pwm: assert property (
      (mode == MODE_CPWM && COUNT_I == value_reg && !COUNT_DOWN_I)
      |=> PIN_O == $past(els[0]))
      else $error("center PWM wrong level at up-count match");

   a_compare_hold: assert property (
      (mode == MODE_COMPARE && COUNT_I != value_reg) |=> $stable(PIN_O))
      else $error("compare output moved without match");

   a_value_reset: assert property (
      @(posedge CLK_SYS_I) disable iff (1'b0)
      SRST_I |=> value_reg == VAL_RESET)
      else $error("value register not cleared by reset");

   a_irq_level: assert property (
      IRQ_O == $past(|(stat_reg & mask_reg)))
      else $error("interrupt output does not follow status and mask");

   a_match_flag: assert property (
      match_evt |=> stat_reg[INT_MATCH_BIT])
      else $error("compare match did not set its status flag");

   a_apb_wait: assert property (
      (PSEL_I && PENABLE_I && !PREADY_O) |=> PREADY_O)
      else $error("ready did not rise after one wait state");

   a_ready_pulse: assert property (
      PREADY_O |=> !PREADY_O)
      else $error("ready stood longer than one cycle");

   c_capture: cover property (mode == MODE_CAPTURE && capture_evt);
   c_toggle: cover property (mode == MODE_COMPARE && els == 2'h1 && match_evt);
   c_epwm: cover property (mode == MODE_EPWM && OVF_I ##[1:20] match_evt);
   c_irq: cover property ($rose(IRQ_O));

endmodule // timer_channel

/* pin_model.sv */
`timescale 1ns/1ps
module pin_model (
   input  wire logic clk_i, // Bus clock
   output logic      pin_o  // Level seen on the channel pin
);
   initial pin_o = 1'b0;

   // The pin moves just after an edge and then stays quiet for hold cycles,
   // so a later change into capture mode never sees a stray edge
   task automatic drive(input logic lvl, input int hold);
      @(posedge clk_i);
      pin_o <= lvl;
      repeat (hold) @(posedge clk_i);
   endtask
endmodule // pin_model

/* tb.sv */
`timescale 1ns/1ps
module tb;
   import timer_channel_pkg::*;
   logic             clk = 1'b0;
   logic             srst = 1'b1;
   logic             psel = 1'b0;
   logic             pen = 1'b0;
   logic             pw = 1'b0;
   logic [7:0]       pa = 8'h00;
   logic [31:0]      pwd = 32'h0;
   logic [31:0]      prd;
   logic             prdy;
   logic             perr;
   logic [VAL_W-1:0] cnt = 16'h0000;
   logic             down = 1'b0;
   logic             ovf = 1'b0;
   logic             pin;
   logic             pout;
   logic             poe;
   logic             irq;
   logic [32:0]      expq[$];
   logic [32:0]      e;
   logic [15:0]      lf = 16'h003b;
   logic [15:0]      v, r1, r2, w;
   logic             pe = 1'b0;
   int               mismatches = 0;
   int               total_checks = 0;
   int               cyc = 0;
   logic [7:0]       pwm_ctl[8] = '{8'h28, 8'h28, 8'h24, 8'h24, 8'h39, 8'h39, 8'h05, 8'h05};
   int               pwm_ev[8] = '{0, 1, 0, 1, 1, 2, 1, 2};
   logic             pwm_exp[8] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

   always #12.5 clk = ~clk;

   timer_channel u_timer_channel (
      .CLK_SYS_I(clk), .SRST_I(srst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pw),
      .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
      .COUNT_I(cnt), .COUNT_DOWN_I(down), .OVF_I(ovf), .PIN_I(pin), .PIN_O(pout),
      .PIN_OE_O(poe), .IRQ_O(irq)
   );
   pin_model u_pin_model (.clk_i(clk), .pin_o(pin));

   function automatic logic [15:0] rnd();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return lf;
   endfunction

   task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] ex);
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pw <= wr;
      pa <= a;
      pwd <= d;
      if (!wr) expq.push_back(ex);
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (prdy !== 1'b1);
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d}, 33'h0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d);
      apb(1'b0, a, 32'h0, {1'b0, d});
   endtask

   // Counter event: 0 wrap, 1 match counting up, 2 match counting down
   task automatic pulse(input int ev);
      @(posedge clk);
      if (ev == 0) ovf <= 1'b1;
      else cnt <= v;
      down <= (ev == 2);
      @(posedge clk);
      ovf <= 1'b0;
      cnt <= 16'h0000;
      down <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   // Read answers are matched in completion order against the oldest note
   always @(posedge clk) begin
      if (psel && pen && prdy === 1'b1 && !pw) begin
         e = expq.pop_front();
         cmp({perr, prd}, e);
      end
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         close_out();
      end
   end

   initial begin
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      rd(OFS_CTL, 32'h0);
      rd(OFS_VAL_HI, 32'h0);
      rd(OFS_VAL_LO, 32'h0);
      rd(OFS_INT_MASK, 32'h0);
      rd(OFS_INT_STAT, 32'h0);
      apb(1'b0, 8'h18, 32'h0, {1'b1, 32'h0});
      v = rnd() | 16'h0100;
      wr8(OFS_VAL_HI, v[15:8]);
      wr8(OFS_VAL_LO, v[7:0]);
      rd(OFS_VAL_HI, {24'h0, v[15:8]});
      rd(OFS_VAL_LO, {24'h0, v[7:0]});
      wr8(OFS_CTL, 8'h31);
      pulse(1);
      rd(OFS_PIN_STATE, 32'h0);
      cmp({31'h0, pout, poe}, 33'h0);
      for (int k = 1; k < 4; k++) begin
         wr8(OFS_CTL, 8'h10 | 8'(k << 2));
         pulse(1);
         pe = (k == 1) ? ~pe : k[1] & k[0];
         rd(OFS_PIN_STATE, {29'h0, 1'b0, pe, 1'b1});
         cmp({31'h0, pout, poe}, {31'h0, pe, 1'b1});
      end
      rd(OFS_INT_STAT, 32'h2);
      for (int k = 1; k < 4; k++) begin
         wr8(OFS_CTL, 8'(k << 2));
         r1 = rnd();
         cnt <= r1;
         u_pin_model.drive(1'b1, 6);
         r2 = rnd();
         cnt <= r2;
         u_pin_model.drive(1'b0, 6);
         cnt <= 16'h0000;
         w = (k == 1) ? r1 : r2;
         rd(OFS_VAL_HI, {24'h0, w[15:8]});
         rd(OFS_VAL_LO, {24'h0, w[7:0]});
      end
      cmp({32'h0, irq}, 33'h0);
      wr8(OFS_INT_MASK, 8'h01);
      repeat (3) @(posedge clk);
      cmp({32'h0, irq}, 33'h1);
      rd(OFS_INT_STAT, 32'h1);
      repeat (3) @(posedge clk);
      cmp({32'h0, irq}, 33'h0);
      wr8(OFS_VAL_HI, v[15:8]);
      wr8(OFS_VAL_LO, v[7:0]);
      for (int k = 0; k < 8; k++) begin
         wr8(OFS_CTL, pwm_ctl[k]);
         pulse(pwm_ev[k]);
         rd(OFS_PIN_STATE, {29'h0, 1'b0, pwm_exp[k], 1'b1});
         cmp({31'h0, pout, poe}, {31'h0, pwm_exp[k], 1'b1});
      end
      repeat (4) @(posedge clk);
      close_out();
   end
endmodule // tb
